// *** hw/csrf_pkg.sv ***
// Constants, field layouts and carrier types for the comb scale and RAM filter channel.
// Assumes one 25 MHz chip clock and AHB-Lite register access, one word per register.
// Notes on behaviour
// [RQ1] Strong-signal scale in low five bits
// [RQ2] Weak-signal scale in next five bits
// [RQ3] Exponent step 6 dB, or 12 dB
// [RQ4] Invert bit inverts external exponent first
// [RQ5] Software sets invert to suit converter
// [RQ6] One-over-one ratio bypasses stage, keeps scaling
// [RQ7] Comb input rate within clock per channel
// [RQ8] Fifth-order comb decimates two to thirty-two
// [RQ9] Five integrator/comb sections, gain two^-(S+5)
// [RQ10] Fifth comb scale factor zero to twenty
// [RQ11] Software picks smallest non-overflowing scale
// [RQ12] Fifth comb output rate is input/ratio
// [RQ13] Fifth comb takes a sample every clock
// [RQ14] Data memories keep 160 complex 20-bit samples
// [RQ15] Coefficient memory holds 256 20-bit words
// [RQ16] One I and one Q tap per clock
// [RQ17] Filter output carries 24 data bits
// [RQ18] Eight-bit decimation register holds ratio minus one
// [RQ19] Decimation counter preloads with phase value
// [RQ20] Polyphase pairs use phases half ratio apart
// [RQ21] Scalar plus fields plus offset below 32
// [RQ22] Resampler ratios held as value minus one
// [RQ23] Attenuator engaged picks strong field, else weak
package csrf_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_RS_DEC    = 8'h90;
	localparam logic [7:0] IDX_RS_INT    = 8'h91;
	localparam logic [7:0] IDX_SCALE     = 8'h92;
	localparam logic [7:0] IDX_RCF_DEC   = 8'hA0;
	localparam logic [7:0] IDX_RCF_PHASE = 8'hA1;
	localparam logic [7:0] IDX_FIFTH_CFG = 8'hB0;
	localparam logic [7:0] IDX_COEF_WR   = 8'hB1;
	localparam logic [7:0] IDX_STATUS    = 8'hB2;
	// Scale register fields
	localparam int LOUD_LSB  = 0;
	localparam int QUIET_LSB = 5;
	localparam int STEP_BIT  = 10;
	localparam int INV_BIT   = 11;
	// Fifth comb config fields
	localparam int F_RATIO_LSB = 0;
	localparam int F_SCALE_LSB = 8;
	localparam int F_TAPS_LSB  = 16;
	localparam logic [4:0] F_SCALE_MAX = 5'h14;
	localparam logic [4:0] F_GAIN_OFS  = 5'h05;
	// Coefficient write word
	localparam int COEF_ADDR_LSB = 20;
	// Widths and depths
	localparam int SW        = 20;
	localparam int OW        = 24;
	localparam int DDEPTH    = 160;
	localparam int CDEPTH    = 256;
	localparam int ACC_W     = 48;
	localparam int OUT_LSB   = 19;
	localparam logic [7:0] TAPS_MAX_M1 = 8'h9F;
	localparam logic [4:0] SHIFT_MAX   = 5'h1F;
	// Reset values
	localparam logic [11:0] SCALE_RST = 12'h000;
	localparam logic [7:0]  BYTE_RST  = 8'h00;

	typedef struct packed {
		logic          valid;
		logic [SW-1:0] i;
		logic [SW-1:0] q;
		logic [2:0]    expo;
		logic          atten;
	} csrf_samp_t;

	typedef struct packed {
		logic          valid;
		logic [OW-1:0] i;
		logic [OW-1:0] q;
	} csrf_out_t;

	typedef enum logic {SEQ_IDLE, SEQ_RUN} csrf_seq_t;
endpackage : csrf_pkg

// *** hw/csrf_ram.sv ***
// Simple two-port memory: one write port, one read port with registered data.
// Assumes a single clock; contents are not reset.
module csrf_ram #(
	parameter int W  = 20,
	parameter int D  = 256,
	parameter int AW = 8
) (
	input  wire logic          clk,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [W-1:0]  wdata,
	input  wire logic          re,
	input  wire logic [AW-1:0] raddr,
	output      logic [W-1:0]  rdata
);
	logic [W-1:0] mem [0:D-1];

	// Write port
	always_ff @(posedge clk) begin
		if (we)
			mem[waddr] <= wdata;
	end

	// Registered read keeps the multiplier input timing clean
	always_ff @(posedge clk) begin
		if (re)
			rdata <= mem[raddr];
	end
endmodule : csrf_ram

// *** hw/csrf_fifth_comb.sv ***
// Fifth-order integrator/comb decimator for one component of the sample stream.
// Assumes software keeps the ratio in range and picks a scale that avoids overflow.
module csrf_fifth_comb
	import csrf_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          rstn,
	input  wire logic          in_valid,
	input  wire logic [SW-1:0] in_data,
	input  wire logic [4:0]    ratio_m1,
	input  wire logic [4:0]    scale,
	output      logic          out_valid,
	output      logic [SW-1:0] out_data
);
	localparam int AW = SW + 26;
	logic signed [AW-1:0] ig [0:5];
	logic signed [AW-1:0] cb [0:5];
	logic signed [AW-1:0] dly [0:4];
	logic [4:0]           dec_reg;
	logic [4:0]           rm1;
	logic [5:0]           shamt;
	logic signed [AW-1:0] shifted;

	default clocking cb_clk @(posedge clk); endclocking
	default disable iff (!rstn);

	// Ratio of one is not legal; clamp to two
	assign rm1 = (ratio_m1 == 5'h00) ? 5'h01 : ratio_m1;
	assign ig[0] = AW'(signed'(in_data));
	assign cb[0] = ig[5];

	// [RQ9] five cascaded sections
	// [RQ13] integrators take a sample on every clock with in_valid high
	for (genvar k = 0; k < 5; k++) begin : g_sect
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn)
				ig[k+1] <= '0;
			else if (in_valid)
				ig[k+1] <= ig[k+1] + ig[k];
		end
		assign cb[k+1] = cb[k] - dly[k];
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn)
				dly[k] <= '0;
			else if (in_valid && dec_reg == rm1)
				dly[k] <= cb[k];
		end
	end

	// [RQ8] decimation counter, ratios 2..32
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			dec_reg <= '0;
		else if (in_valid)
			dec_reg <= (dec_reg >= rm1) ? 5'h00 : dec_reg + 5'h01;
	end

	// [RQ10] scale clamped to 0..20
	assign shamt = 6'((scale > F_SCALE_MAX) ? F_SCALE_MAX : scale) + 6'(F_GAIN_OFS);
	// [RQ9] gain of two to the -(S+5)
	assign shifted = cb[5] >>> shamt;

	// [RQ12] one output per ratio inputs
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			out_valid <= 1'b0;
			out_data  <= '0;
		end else begin
			out_valid <= in_valid && dec_reg == rm1;
			if (in_valid && dec_reg == rm1)
				out_data <= shifted[SW-1:0];
		end
	end

	// [RQ12] output only at counter wrap
	rate_gate_a: assert property (out_valid |-> $past(in_valid) && $past(dec_reg) == $past(rm1))
		else $error("comb output off its decimation slot");
	// [RQ8] counter never passes the ratio
	count_range_a: assert property (dec_reg <= rm1 || $changed(rm1))
		else $error("comb counter beyond ratio");
endmodule : csrf_fifth_comb

// *** hw/csrf_top.sv ***
// Channel middle and final stages: comb input scaling, fifth-order comb, RAM filter.
// Assumes the sample stream and exponent bits arrive on clk, registers over AHB-Lite.
module csrf_top
	import csrf_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                rstn,
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output      logic                hreadyout,
	output      logic                hresp,
	output      logic [31:0]         hrdata,
	input  wire csrf_pkg::csrf_samp_t samp_in,
	output      csrf_pkg::csrf_out_t  filt_out
);
	import csrf_pkg::*;

	default clocking cb_clk @(posedge clk); endclocking
	default disable iff (!rstn);

	////////////////////////////////////////////////////////////////////////////
	// Register bus

	// Decode shared by read mux and write strobes
	function automatic logic in_map(input logic [31:0] a);
		return a[31:10] == 22'h000000 && a[1:0] == 2'h0;
	endfunction : in_map

	logic        addr_ok;
	logic        wr_pend_reg;
	logic [7:0]  widx_reg;
	logic [11:0] rs_dec_reg;
	logic [8:0]  rs_int_reg;
	logic [11:0] scale_reg;
	logic [7:0]  rcf_dec_reg;
	logic [7:0]  rcf_phase_reg;
	logic [23:0] fifth_cfg_reg;
	logic [31:0] rd_word;
	logic        busy;
	logic [7:0]  rcf_cnt_reg;
	logic [4:0]  shift_reg;
	logic        bypass;

	assign addr_ok = hsel && htrans[1] && hready;

	// Address phase capture; writes land in the data phase
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_pend_reg <= 1'b0;
			widx_reg    <= BYTE_RST;
		end else begin
			wr_pend_reg <= addr_ok && hwrite && in_map(haddr);
			widx_reg    <= haddr[9:2];
		end
	end

	// Zero wait states, always OKAY
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// Configuration registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rs_dec_reg    <= '0;
			rs_int_reg    <= '0;
			scale_reg     <= SCALE_RST;
			rcf_dec_reg   <= BYTE_RST;
			rcf_phase_reg <= BYTE_RST;
			fifth_cfg_reg <= '0;
		end else if (wr_pend_reg) begin
			case (widx_reg)
				// [RQ22] ratios stored minus one
				IDX_RS_DEC:    rs_dec_reg <= hwdata[11:0];
				IDX_RS_INT:    rs_int_reg <= hwdata[8:0];
				// [RQ1] [RQ2] scale fields, plus step and invert bits
				IDX_SCALE:     scale_reg <= hwdata[11:0];
				// [RQ18] ratio minus one
				IDX_RCF_DEC:   rcf_dec_reg <= hwdata[7:0];
				IDX_RCF_PHASE: rcf_phase_reg <= hwdata[7:0];
				IDX_FIFTH_CFG: fifth_cfg_reg <= hwdata[23:0];
				default: ;
			endcase
		end
	end

	// Read mux; unmapped words read zero
	always_comb begin
		rd_word = 32'h0000_0000;
		case (haddr[9:2])
			IDX_RS_DEC:    rd_word = {20'h00000, rs_dec_reg};
			IDX_RS_INT:    rd_word = {23'h000000, rs_int_reg};
			IDX_SCALE:     rd_word = {20'h00000, scale_reg};
			IDX_RCF_DEC:   rd_word = {24'h000000, rcf_dec_reg};
			IDX_RCF_PHASE: rd_word = {24'h000000, rcf_phase_reg};
			IDX_FIFTH_CFG: rd_word = {8'h00, fifth_cfg_reg};
			IDX_STATUS:    rd_word = {16'h0000, rcf_cnt_reg, 1'b0, shift_reg, bypass, busy};
			default:       rd_word = 32'h0000_0000;
		endcase
	end

	// Read data registered at the address phase edge
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			hrdata <= 32'h0000_0000;
		else if (addr_ok && !hwrite)
			hrdata <= in_map(haddr) ? rd_word : 32'h0000_0000;
	end

	// [RQ1] strong field follows its write
	loud_field_a: assert property ($past(wr_pend_reg) && $past(widx_reg) == IDX_SCALE
		|-> scale_reg[4:0] == $past(hwdata[4:0])) else $error("strong scale not stored"); // [RQ1]
	// [RQ2] weak field follows its write
	quiet_field_a: assert property ($past(wr_pend_reg) && $past(widx_reg) == IDX_SCALE
		|-> scale_reg[9:5] == $past(hwdata[9:5])) else $error("weak scale not stored"); // [RQ2]

	////////////////////////////////////////////////////////////////////////////
	// Comb input scaling

	logic [2:0]    exp_eff;
	logic [3:0]    exp_steps;
	logic [4:0]    base_scale;
	logic [5:0]    total;
	logic          sc_valid_reg;
	logic [SW-1:0] sc_i_reg;
	logic [SW-1:0] sc_q_reg;

	// [RQ6] one-over-one shows as bypass; scaling below still applies
	assign bypass = rs_dec_reg == 12'h000 && rs_int_reg == 9'h000;
	// [RQ4] invert before use
	assign exp_eff = scale_reg[INV_BIT] ? ~samp_in.expo : samp_in.expo;
	// [RQ3] 6 dB or 12 dB per step
	assign exp_steps = scale_reg[STEP_BIT] ? {exp_eff, 1'b0} : {1'b0, exp_eff};
	// [RQ23] attenuator engaged selects strong field
	assign base_scale = samp_in.atten ? scale_reg[LOUD_LSB +: 5] : scale_reg[QUIET_LSB +: 5];
	// Saturate: a shift past 31 would wrap and amplify
	assign total = 6'(base_scale) + 6'(exp_steps);

	// [RQ6] scaling stage, kept in bypass
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sc_valid_reg <= 1'b0;
			sc_i_reg     <= '0;
			sc_q_reg     <= '0;
			shift_reg    <= '0;
		end else begin
			sc_valid_reg <= samp_in.valid;
			if (samp_in.valid) begin
				shift_reg <= (total > 6'(SHIFT_MAX)) ? SHIFT_MAX : total[4:0];
				sc_i_reg  <= SW'($signed(samp_in.i) >>> ((total > 6'(SHIFT_MAX)) ? SHIFT_MAX : total[4:0]));
				sc_q_reg  <= SW'($signed(samp_in.q) >>> ((total > 6'(SHIFT_MAX)) ? SHIFT_MAX : total[4:0]));
			end
		end
	end

	// [RQ23] field picked with the sample it scales
	sel_sync_a: assert property (samp_in.valid && !samp_in.atten && samp_in.expo == 3'h0
		&& !scale_reg[INV_BIT] |=> shift_reg == $past(scale_reg[9:5])) else $error("weak field not used"); // [RQ23]
	// [RQ3] 12 dB step doubles the exponent
	exp_step_a: assert property (samp_in.valid && samp_in.atten && scale_reg[STEP_BIT]
		&& !scale_reg[INV_BIT] && scale_reg[4:0] == 5'h00 |=> shift_reg == {1'b0, $past(samp_in.expo), 1'b0})
		else $error("exponent step weight wrong"); // [RQ3]
	// [RQ4] inverted exponent feeds the shift
	exp_inv_a: assert property (samp_in.valid && samp_in.atten && !scale_reg[STEP_BIT]
		&& scale_reg[INV_BIT] && scale_reg[4:0] == 5'h00 |=> shift_reg == {2'b00, ~$past(samp_in.expo)})
		else $error("exponent not inverted"); // [RQ4]

	////////////////////////////////////////////////////////////////////////////
	// Fifth-order comb, both components

	logic          f_valid;
	logic [SW-1:0] f_i;
	logic [SW-1:0] f_q;

	csrf_fifth_comb u_comb_i (
		.clk       (clk),
		.rstn      (rstn),
		.in_valid  (sc_valid_reg),
		.in_data   (sc_i_reg),
		.ratio_m1  (fifth_cfg_reg[F_RATIO_LSB +: 5]),
		.scale     (fifth_cfg_reg[F_SCALE_LSB +: 5]),
		.out_valid (f_valid),
		.out_data  (f_i)
	);

	csrf_fifth_comb u_comb_q (
		.clk       (clk),
		.rstn      (rstn),
		.in_valid  (sc_valid_reg),
		.in_data   (sc_q_reg),
		.ratio_m1  (fifth_cfg_reg[F_RATIO_LSB +: 5]),
		.scale     (fifth_cfg_reg[F_SCALE_LSB +: 5]),
		.out_valid (),
		.out_data  (f_q)
	);

	////////////////////////////////////////////////////////////////////////////
	// RAM filter: decimation counter and sample store

	logic       trig;
	logic [7:0] wptr_reg;

	assign trig = f_valid && rcf_cnt_reg == rcf_dec_reg;

	// [RQ19] counter restarts from the phase value
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			rcf_cnt_reg <= BYTE_RST;
		else if (wr_pend_reg && widx_reg == IDX_RCF_PHASE)
			rcf_cnt_reg <= hwdata[7:0];
		else if (wr_pend_reg && widx_reg == IDX_RCF_DEC)
			rcf_cnt_reg <= rcf_phase_reg;
		// [RQ18] wraps after ratio inputs
		else if (f_valid)
			rcf_cnt_reg <= (rcf_cnt_reg >= rcf_dec_reg) ? 8'h00 : rcf_cnt_reg + 8'h01;
	end

	// [RQ14] circular write pointer over 160 words
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			wptr_reg <= '0;
		else if (f_valid)
			wptr_reg <= (wptr_reg == 8'(DDEPTH - 1)) ? 8'h00 : wptr_reg + 8'h01;
	end

	// [RQ19] phase write preloads the counter
	phase_load_a: assert property (wr_pend_reg && widx_reg == IDX_RCF_PHASE
		|=> rcf_cnt_reg == $past(hwdata[7:0])) else $error("phase not preloaded"); // [RQ19]

	////////////////////////////////////////////////////////////////////////////
	// RAM filter: tap sequencer and accumulators

	csrf_seq_t          seq_reg;
	logic               pend_reg;
	logic [7:0]         rptr_reg;
	logic [7:0]         coef_reg;
	logic [7:0]         left_reg;
	logic [7:0]         ntaps_m1;
	logic [8:0]         start_ptr;
	logic               rd_en;
	logic               rd_vld_reg;
	logic               rd_first_reg;
	logic               rd_last_reg;
	logic               done_reg;
	logic [2*SW-1:0]    dat_word;
	logic [SW-1:0]      coef_word;
	logic signed [ACC_W-1:0] acc_i_reg;
	logic signed [ACC_W-1:0] acc_q_reg;

	assign busy = seq_reg == SEQ_RUN;
	assign rd_en = busy;
	assign ntaps_m1 = (fifth_cfg_reg[F_TAPS_LSB +: 8] > TAPS_MAX_M1) ? TAPS_MAX_M1
		: fifth_cfg_reg[F_TAPS_LSB +: 8];
	// Oldest of the last ntaps samples; the word landing at the trigger edge is the newest
	assign start_ptr = (wptr_reg >= ntaps_m1) ? 9'(wptr_reg - ntaps_m1)
		: 9'(wptr_reg) + 9'(DDEPTH) - 9'(ntaps_m1);

	// [RQ16] one tap pair per clock; late trigger waits as pending
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			seq_reg  <= SEQ_IDLE;
			pend_reg <= 1'b0;
			rptr_reg <= '0;
			coef_reg <= '0;
			left_reg <= '0;
		end else begin
			unique case (seq_reg)
				SEQ_IDLE: if (trig || pend_reg) begin
					seq_reg  <= SEQ_RUN;
					pend_reg <= 1'b0;
					rptr_reg <= start_ptr[7:0];
					coef_reg <= 8'h00;
					left_reg <= ntaps_m1;
				end
				SEQ_RUN: begin
					pend_reg <= pend_reg | trig;
					rptr_reg <= (rptr_reg == 8'(DDEPTH - 1)) ? 8'h00 : rptr_reg + 8'h01;
					coef_reg <= coef_reg + 8'h01;
					left_reg <= left_reg - 8'h01;
					if (left_reg == 8'h00)
						seq_reg <= SEQ_IDLE;
				end
			endcase
		end
	end

	// [RQ14] I and Q sample memory
	csrf_ram #(.W(2 * SW), .D(DDEPTH), .AW(8)) u_data_ram (
		.clk   (clk),
		.we    (f_valid),
		.waddr (wptr_reg),
		.wdata ({f_i, f_q}),
		.re    (rd_en),
		.raddr (rptr_reg),
		.rdata (dat_word)
	);

	// [RQ15] coefficient memory, 256 words
	csrf_ram #(.W(SW), .D(CDEPTH), .AW(8)) u_coef_ram (
		.clk   (clk),
		.we    (wr_pend_reg && widx_reg == IDX_COEF_WR),
		.waddr (hwdata[COEF_ADDR_LSB +: 8]),
		.wdata (hwdata[SW-1:0]),
		.re    (rd_en),
		.raddr (coef_reg),
		.rdata (coef_word)
	);

	// Read pipeline tags
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rd_vld_reg   <= 1'b0;
			rd_first_reg <= 1'b0;
			rd_last_reg  <= 1'b0;
			done_reg     <= 1'b0;
		end else begin
			rd_vld_reg   <= rd_en;
			rd_first_reg <= rd_en && coef_reg == 8'h00;
			rd_last_reg  <= rd_en && left_reg == 8'h00;
			done_reg     <= rd_vld_reg && rd_last_reg;
		end
	end

	// [RQ16] same coefficient for I and Q
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			acc_i_reg <= '0;
			acc_q_reg <= '0;
		end else if (rd_vld_reg) begin
			acc_i_reg <= (rd_first_reg ? '0 : acc_i_reg)
				+ ACC_W'($signed(dat_word[2*SW-1:SW]) * $signed(coef_word));
			acc_q_reg <= (rd_first_reg ? '0 : acc_q_reg)
				+ ACC_W'($signed(dat_word[SW-1:0]) * $signed(coef_word));
		end
	end

	// [RQ17] 24-bit result, one-cycle valid
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			filt_out <= '0;
		else begin
			filt_out.valid <= done_reg;
			if (done_reg) begin
				filt_out.i <= acc_i_reg[OUT_LSB +: OW];
				filt_out.q <= acc_q_reg[OUT_LSB +: OW];
			end
		end
	end

	sequence start_s;
		seq_reg == SEQ_IDLE && (trig || pend_reg);
	endsequence
	sequence taps_s;
		busy [*2];
	endsequence
	// [RQ16] a run of at least two taps stays busy
	tap_run_a: assert property (start_s ##1 (left_reg >= 8'h01) |-> taps_s)
		else $error("tap run ended early"); // [RQ16]
	// [RQ18] trigger only at the decimation slot
	dec_trig_a: assert property (start_s and !pend_reg |-> f_valid && rcf_cnt_reg == rcf_dec_reg)
		else $error("filter started off its slot"); // [RQ18]
	// [RQ17] output follows the last tap by two
	out_pulse_a: assert property (rd_vld_reg && rd_last_reg |-> ##2 filt_out.valid ##1 !filt_out.valid)
		else $error("output pulse misplaced"); // [RQ17]
endmodule : csrf_top

// *** verification/csrf_adc_model.sv ***
// Gain-ranging converter model driving the channel sample stream.
// Assumes the bench sets level, exponent and attenuator between bursts.
module csrf_adc_model
	import csrf_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rstn,
	input  wire logic                 run,
	input  wire logic                 slow,
	input  wire logic [SW-1:0]        lvl_i,
	input  wire logic [SW-1:0]        lvl_q,
	input  wire logic [2:0]           expo,
	input  wire logic                 atten,
	output      csrf_pkg::csrf_samp_t samp
);
	timeunit 1ns;
	timeprecision 1ns;
	logic alt_reg;
	logic fire;
	////////////////////////////////////////
	// Slow mode offers a sample every other clock
	assign fire = run && (!slow || alt_reg);
	// One sample per clock in fast mode
	// Idle data flips each cycle so stale words never pass for samples
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			samp    <= '0;
			alt_reg <= 1'b0;
		end else begin
			alt_reg    <= ~alt_reg;
			samp.valid <= fire;
			samp.expo  <= expo;
			samp.atten <= atten;
			samp.i     <= fire ? lvl_i : ~samp.i;
			samp.q     <= fire ? lvl_q : ~samp.q;
		end
	end
endmodule : csrf_adc_model

// *** verification/csrf_top_tb_top.sv ***
// Self-checking bench for the comb scale and RAM filter channel.
// Assumes one 25 MHz clock and the converter model on the stream.
module csrf_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import csrf_pkg::*;
	localparam logic [7:0]  RIDX[5]  = '{IDX_RS_DEC, IDX_RS_INT, IDX_SCALE,
		IDX_RCF_DEC, IDX_RCF_PHASE};
	localparam logic [31:0] RMASK[5] = '{32'hFFF, 32'h1FF, 32'hFFF, 32'hFF, 32'hFF};
	// Every row keeps the shift sum below 32
	localparam logic [11:0] SCV[5] = '{12'h123, 12'h123, 12'h523, 12'h923, 12'hD23};
	localparam logic        ATV[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
	localparam logic [4:0]  SHV[5] = '{5'h05, 5'h0B, 5'h07, 5'h08, 5'h13};
	localparam logic [31:0] CFV[3] = '{32'h1, 32'h503, 32'h141F};
	localparam int          NSV[3] = '{24, 48, 384};
	// Phase half the ratio against phase zero
	localparam logic [31:0] PHV[2] = '{32'h2, 32'h0};
	localparam int          PEX[2] = '{2, 1};
	logic        clk;
	logic        rstn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic [31:0] rd_s;
	logic        run;
	logic        slow;
	logic [2:0]  expo;
	logic        atten;
	csrf_samp_t  samp;
	csrf_out_t   fout;
	csrf_out_t   last_out;
	int          n_out;
	int          num_errors;
	int          n_checks;
	////////////////////////////////////////
	initial clk = 1'b0;
	always #20 clk = ~clk;
	csrf_top dut_u (
		.clk       (clk),
		.rstn      (rstn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hreadyout),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.hrdata    (hrdata),
		.samp_in   (samp),
		.filt_out  (fout)
	);
	csrf_adc_model adc_u (
		.clk   (clk),
		.rstn  (rstn),
		.run   (run),
		.slow  (slow),
		.lvl_i (20'h007D0),
		.lvl_q (20'hFFC18),
		.expo  (expo),
		.atten (atten),
		.samp  (samp)
	);
	// Results taken at the falling edge, clear of register updates
	always @(negedge clk) begin
		if (fout.valid === 1'b1) begin
			n_out++;
			last_out = fout;
		end
	end
	////////////////////////////////////////
	task automatic end_of_test;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : check
	function automatic logic [31:0] ba(input logic [7:0] x);
		return {22'h0, x, 2'b00};
	endfunction : ba
	// Ready and read data both taken at the rising edge that ends the phase
	task automatic wait_rdy;
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (hreadyout !== 1'b1 && k < 30);
		if (hreadyout !== 1'b1) begin
			num_errors++;
			end_of_test();
		end
		rd_s = hrdata;
	endtask : wait_rdy
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'b10;
		hwrite <= w;
		wait_rdy();
		htrans <= 2'b00;
		hwdata <= d;
		wait_rdy();
	endtask : bus
	task automatic rc(input logic [31:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check($sformatf("addr %h", a), rd_s, e);
	endtask : rc
	// Fast bursts give a sample every clock
	task automatic feed(input int n, input logic sl);
		@(posedge clk);
		run  <= 1'b1;
		slow <= sl;
		repeat (sl ? 2 * n : n) @(posedge clk);
		run <= 1'b0;
	endtask : feed
	task automatic drain(input int tgt);
		for (int k = 0; k < 60 && n_out < tgt; k++)
			@(negedge clk);
		if (n_out < tgt) begin
			num_errors++;
			end_of_test();
		end
		repeat (12) @(negedge clk);
	endtask : drain
	////////////////////////////////////////
	initial begin
		int cnt;
		rstn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		run = 1'b0;
		slow = 1'b0;
		expo = 3'h2;
		atten = 1'b0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		// Register reset values, width, then cleared again
		foreach (RIDX[j]) begin
			rc(ba(RIDX[j]), 32'h0);
			bus(1'b1, ba(RIDX[j]), 32'hFFFFFFFF);
			rc(ba(RIDX[j]), RMASK[j]);
			bus(1'b1, ba(RIDX[j]), 32'h0);
		end
		// Out-of-map write ignored, write-only and unmapped words read zero
		bus(1'b1, 32'h648, 32'hFFFFFFFF);
		rc(ba(IDX_SCALE), 32'h0);
		rc(ba(IDX_COEF_WR), 32'h0);
		rc(32'h3FC, 32'h0);
		// Step and invert rows, attenuator picks the field
		// Invert set only on rows that model a rising-exponent converter
		foreach (SCV[j]) begin
			bus(1'b1, ba(IDX_SCALE), {20'h0, SCV[j]});
			atten <= ATV[j];
			feed(2, 1'b0);
			repeat (4) @(posedge clk);
			bus(1'b0, ba(IDX_STATUS), 32'h0);
			check("shift", {27'h0, rd_s[6:2]}, {27'h0, SHV[j]});
		end
		bus(1'b0, ba(IDX_STATUS), 32'h0);
		check("bypass", {31'h0, rd_s[1]}, 32'h1);
		bus(1'b1, ba(IDX_RS_DEC), 32'h3);
		bus(1'b0, ba(IDX_STATUS), 32'h0);
		check("bypass", {31'h0, rd_s[1]}, 32'h0);
		bus(1'b1, ba(IDX_RS_DEC), 32'h0);
		// Weak field halves input; coefficient of minus one negates it
		bus(1'b1, ba(IDX_SCALE), 32'h020);
		atten <= 1'b0;
		expo  <= 3'h0;
		bus(1'b1, ba(IDX_COEF_WR), 32'h00080000);
		// Ratios two, four and thirty-two, unity gain each
		foreach (CFV[j]) begin
			bus(1'b1, ba(IDX_FIFTH_CFG), CFV[j]);
			cnt = n_out;
			feed(NSV[j], 1'b0);
			drain(cnt + 12);
			check("count", 32'(n_out - cnt), 32'd12);
			check("out i", {8'h0, last_out.i}, 32'h00FFFC18);
			check("out q", {8'h0, last_out.q}, 32'h000001F4);
		end
		// Decimation four with phase preload, converter slow then fast
		bus(1'b1, ba(IDX_FIFTH_CFG), 32'h1);
		foreach (PHV[j]) begin
			bus(1'b1, ba(IDX_RCF_PHASE), PHV[j]);
			bus(1'b1, ba(IDX_RCF_DEC), 32'h3);
			cnt = n_out;
			feed(12, PHV[j] != 32'h0);
			drain(cnt + PEX[j]);
			check("phased count", 32'(n_out - cnt), 32'(PEX[j]));
		end
		end_of_test();
	end
endmodule : csrf_top_tb_top
